// *** sim/integer_multiply_logic_unit_tb_top.sv ***
// Self-checking bench for the integer multiply and logic unit
`timescale 1ns/1ps
module integer_multiply_logic_unit_tb_top;
   import integer_multiply_logic_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   logic [31:0] seed = 32'h42;
   logic [63:0] er = 64'h0;
   logic [5:0] est = 6'h00;
   int num_errors = 0;
   int checked = 0;

   always #5 clock = ~clock;

   integer_multiply_logic_unit u_dut (
      .clock(clock), .rst(rst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
   );

   task automatic close_out;
      $display("errors %0d of %0d checks", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   task automatic rnd(output logic [31:0] v);
      seed = lfsr(seed);
      v = seed;
   endtask

   // Valids held until their own ready; bready held until bvalid seen
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_left;
      logic w_left;
      n = 0;
      aw_left = 1'b1;
      w_left = 1'b1;
      r = 2'h3;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 60) begin
         @(posedge clock);
         n++;
         if (aw_left && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_left = 1'b0;
         end
         if (w_left && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_left = 1'b0;
         end
         if (!aw_left && !w_left && bvalid === 1'b1) begin
            r = bresp;
            n = 99;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      d = 32'hX;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 60) begin
         @(posedge clock);
         n++;
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            n = 99;
         end
      end
      arvalid <= 1'b0;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_write(a, d, rs);
      check_resp("bresp", RESP_OKAY, rs);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, rd, rs);
      check_resp("rresp", RESP_OKAY, rs);
      check_word(name, exp, rd);
   endtask

   // Reference model of one operation, then drive it and compare
   task automatic run_op(input logic [63:0] a, input logic [63:0] b, input logic [31:0] imm, input ctrl_t c);
      logic [63:0] r, s, p;
      logic [15:0] si;
      logic [31:0] lw;
      int op;
      op = int'(c.op);
      s = {64{c.sci_fill}};
      s[c.sci_scale*8 +: 8] = c.sci_byte;
      si = {imm[20:16], imm[10:0]};
      r = er;
      case (op)
         0: begin p = $signed(a[31:0]) * $signed(b[31:0]); r = {32'h0, p[63:32]}; end
         1: begin p = a[31:0] * b[31:0]; r = {32'h0, p[63:32]}; end
         2: r = $signed(a) * $signed({{48{imm[15]}}, imm[15:0]});
         3: begin p = a * s; r = {32'h0, p[31:0]}; end
         4: begin p = a * {{48{si[15]}}, si}; r = {a[63:32], p[31:0]}; end
         5: r = $signed(a[31:0]) * $signed(b[31:0]);
         6: begin p = a * b; r = {a[63:32], p[31:0]}; end
         7: r = ~(a & b);
         8: r = ~a + 64'h1;
         9: r = {a[63:32], ~a[31:0] + 32'h1};
         10: r = a | s;
         11: r = a | {48'h0, si};
         12: r = a | {32'h0, si, 16'h0};
         13: r = a | b;
         default: ;
      endcase
      if (c.overflow_check && (op == 5 || op == 8)) begin
         est[4] = (op == 5) ? (r[63:32] != 32'h0 && r[63:32] != 32'hFFFFFFFF) : (a[31:0] == MOST_NEG32);
         est[5] = est[5] | est[4];
      end
      lw = r[31:0];
      if (c.cr_update_select && op inside {0, 1, 5, 7, 8, 10, 11, 12})
         est[3:0] = {$signed(lw) < 0, $signed(lw) > 0, lw == 32'h0, est[5]};
      er = r;
      wr(OFS_SRC_A_LO, a[31:0]);
      wr(OFS_SRC_A_HI, a[63:32]);
      wr(OFS_SRC_B_LO, b[31:0]);
      wr(OFS_SRC_B_HI, b[63:32]);
      wr(OFS_IMM, imm);
      wr(OFS_CTRL, {15'h0, c});
      rd_chk("result_lo", OFS_RESULT_LO, er[31:0]);
      rd_chk("result_hi", OFS_RESULT_HI, er[63:32]);
      if (op inside {4, 6, 9})
         rd_chk("src_a_lo", OFS_SRC_A_LO, er[31:0]);
      rd_chk("status", OFS_STATUS, {26'h0, est});
   endtask

   initial begin
      repeat (30000) @(posedge clock);
      num_errors++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      logic [31:0] t0, t1, t2, t3, t4, t5;
      ctrl_t c;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      rd_chk("status", OFS_STATUS, 32'h0);
      axi_write(8'h40, 32'h1, rs);
      check_resp("bresp", RESP_SLVERR, rs);
      axi_read(8'h24, rd, rs);
      check_resp("rresp", RESP_SLVERR, rs);
      check_word("rdata", 32'h0, rd);
      $display("test unmapped done");
      for (int k = 0; k < 42; k++) begin
         rnd(t0);
         rnd(t1);
         rnd(t2);
         rnd(t3);
         rnd(t4);
         rnd(t5);
         c = ctrl_t'(t4[16:0]);
         c.op = op_t'(4'(k % 14));
         if (t5[31]) begin
            wr(OFS_STATUS, 32'h30);
            est[5:4] = 2'b00;
         end
         run_op({t0, t1}, {t2, t3}, t5, c);
      end
      $display("test random_ops done");
      c = CTRL_RESET;
      c.overflow_check = 1'b1;
      c.cr_update_select = 1'b1;
      c.op = OP_TWOS_COMPLEMENT;
      run_op(MOST_NEG64, 64'h0, 32'h0, c);
      run_op(64'h0000_0001_8000_0000, 64'h0, 32'h0, c);
      c.op = OP_MULTIPLY_LOW_WORD;
      run_op(64'h3, 64'hFFFF_FFFB, 32'h0, c);
      run_op(64'h7FFF_FFFF, 64'h7FFF_FFFF, 32'h0, c);
      c.op = OP_SHORT_TWOS_COMPLEMENT;
      run_op(64'h1234_5678_8000_0000, 64'h0, 32'h0, c);
      c.op = op_t'(4'hE);
      run_op(64'h5, 64'h7, 32'h0, c);
      wr(OFS_STATUS, 32'h30);
      est[5:4] = 2'b00;
      rd_chk("status", OFS_STATUS, {26'h0, est});
      wr(OFS_RESULT_LO, 32'hFFFF_FFFF);
      rd_chk("result_lo", OFS_RESULT_LO, er[31:0]);
      $display("test corners done");
      close_out();
   end
endmodule

// *** src/integer_multiply_logic_pkg.sv ***
// Constants, field layouts and types for the integer multiply and logic unit
package integer_multiply_logic_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_SRC_A_LO = 8'h00;
   localparam logic [7:0] OFS_SRC_A_HI = 8'h04;
   localparam logic [7:0] OFS_SRC_B_LO = 8'h08;
   localparam logic [7:0] OFS_SRC_B_HI = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_IMM = 8'h14;
   localparam logic [7:0] OFS_RESULT_LO = 8'h18;
   localparam logic [7:0] OFS_RESULT_HI = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Immediate register field positions
   localparam int IMM16_LSB = 0;
   localparam int SPLIT_HI_LSB = 16;
   localparam int SPLIT_LO_LSB = 0;
   // Status write-one-to-clear bit positions
   localparam int STATUS_WIDE_BIT = 4;
   localparam int STATUS_SO_BIT = 5;
   localparam logic [63:0] MOST_NEG64 = 64'h8000_0000_0000_0000;
   localparam logic [31:0] MOST_NEG32 = 32'h8000_0000;

   typedef enum logic [3:0] {
      OP_MULTIPLY_HIGH_SIGNED,
      OP_MULTIPLY_HIGH_UNSIGNED,
      OP_MULTIPLY_SIGNED_IMM16,
      OP_MULTIPLY_SCALED_BYTE_IMM,
      OP_MULTIPLY_IN_PLACE_IMM,
      OP_MULTIPLY_LOW_WORD,
      OP_SHORT_MULTIPLY_LOW,
      OP_NOT_AND,
      OP_TWOS_COMPLEMENT,
      OP_SHORT_TWOS_COMPLEMENT,
      OP_OR_SCALED_BYTE_IMM,
      OP_OR_LOW_HALF_IMM,
      OP_OR_HIGH_HALF_IMM,
      OP_SHORT_OR_OP
   } op_t;

   // Control word: op [3:0], record [4], overflow check [5], fill [6], scale [8:7], byte [16:9]
   typedef struct packed {
      logic [7:0] sci_byte;
      logic [1:0] sci_scale;
      logic sci_fill;
      logic overflow_check;
      logic cr_update_select;
      op_t op;
   } ctrl_t;

   typedef struct packed {
      logic sticky_error_flag;
      logic result_too_wide_flag;
      logic [3:0] cond_field_zero;
   } status_t;

   localparam ctrl_t CTRL_RESET = '0;
   localparam status_t STATUS_RESET = '0;
endpackage

// *** src/integer_multiply_logic_unit.sv ***
// Integer multiply, not-and, negate and OR datapath behind an AXI4-Lite slave
// How it works
// RULE_01: signed high word of low-word product
// RULE_02: unsigned high word of low-word product
// RULE_03: high-multiply upper destination half undefined
// RULE_04: record select sets condition field from high
// RULE_05: signed immediate times register, low 64 bits
// RULE_06: scaled byte multiply, low word, no flags
// RULE_07: joined split immediate multiply back into source
// RULE_08: low-word multiply writes full 64-bit product
// RULE_09: overflow check flags non-extended upper word
// RULE_10: record select tests low product word
// RULE_11: short multiply into first register, no flags
// RULE_12: not-and with optional condition update
// RULE_13: negate as inverse plus one, record test
// RULE_14: most negative 64-bit value returns unchanged
// RULE_15: negate overflow from carries of bits 32/33
// RULE_16: short negate in place, no flags
// RULE_17: OR with byte, halfword immediate or register
// RULE_18: scaled byte expands into chosen lane with fill
`timescale 1ns/1ps
module integer_multiply_logic_unit (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Write address channel
   input wire logic awvalid,
   output logic awready,
   input wire logic [integer_multiply_logic_pkg::ADDR_W-1:0] awaddr,
   // Write data channel
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // Write response channel
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // Read address channel
   input wire logic arvalid,
   output logic arready,
   input wire logic [integer_multiply_logic_pkg::ADDR_W-1:0] araddr,
   // Read data channel
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   import integer_multiply_logic_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Sign test of a word, with the sticky flag in the last bit
   function automatic logic [3:0] cr_of(input logic [31:0] v, input logic so);
      return {v[31], ~v[31] & (|v), ~(|v), so};
   endfunction

   function automatic logic [63:0] expand_byte_imm(input logic fill, input logic [1:0] scale, input logic [7:0] b);
      logic [63:0] r;
      r = {64{fill}};
      r[{scale, 3'b000} +: 8] = b;
      return r;
   endfunction

   function automatic logic [15:0] join_split(input logic [31:0] imm);
      return {imm[SPLIT_HI_LSB +: 5], imm[SPLIT_LO_LSB +: 11]};
   endfunction

   // Bus state
   logic aw_have_reg, w_have_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   // Datapath state
   logic [63:0] src_a_gpr_reg, src_b_gpr_reg, result_reg;
   logic [31:0] imm_reg;
   ctrl_t ctrl_reg;
   status_t status_reg, status_next;
   logic go_reg;

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   // Write decode
   wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   wire wr_a_lo = do_write && aw_addr_reg == OFS_SRC_A_LO;
   wire wr_a_hi = do_write && aw_addr_reg == OFS_SRC_A_HI;
   wire wr_b_lo = do_write && aw_addr_reg == OFS_SRC_B_LO;
   wire wr_b_hi = do_write && aw_addr_reg == OFS_SRC_B_HI;
   wire wr_ctrl = do_write && aw_addr_reg == OFS_CTRL;
   wire wr_imm = do_write && aw_addr_reg == OFS_IMM;
   wire wr_status = do_write && aw_addr_reg == OFS_STATUS;
   wire wr_hit = wr_a_lo || wr_a_hi || wr_b_lo || wr_b_hi || wr_ctrl || wr_imm || wr_status
                 || aw_addr_reg == OFS_RESULT_LO || aw_addr_reg == OFS_RESULT_HI;
   wire [31:0] ctrl_merged = merge({15'h0000, ctrl_reg}, w_data_reg, w_strb_reg);

   // Read decode
   wire rd_hit = araddr == OFS_SRC_A_LO || araddr == OFS_SRC_A_HI || araddr == OFS_SRC_B_LO
                 || araddr == OFS_SRC_B_HI || araddr == OFS_CTRL || araddr == OFS_IMM
                 || araddr == OFS_RESULT_LO || araddr == OFS_RESULT_HI || araddr == OFS_STATUS;
   wire [31:0] rd_word = araddr == OFS_SRC_A_LO ? src_a_gpr_reg[31:0] :
                         araddr == OFS_SRC_A_HI ? src_a_gpr_reg[63:32] :
                         araddr == OFS_SRC_B_LO ? src_b_gpr_reg[31:0] :
                         araddr == OFS_SRC_B_HI ? src_b_gpr_reg[63:32] :
                         araddr == OFS_CTRL ? {15'h0000, ctrl_reg} :
                         araddr == OFS_IMM ? imm_reg :
                         araddr == OFS_RESULT_LO ? result_reg[31:0] :
                         araddr == OFS_RESULT_HI ? result_reg[63:32] :
                         araddr == OFS_STATUS ? {26'h0000000, status_reg} : 32'h0000_0000;

   always_ff @(posedge clock) begin
      if (rst) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         awready_reg <= awvalid && !aw_have_reg && !awready_reg;
         wready_reg <= wvalid && !w_have_reg && !wready_reg;
         if (awvalid && awready_reg) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end else if (do_write) begin
            aw_have_reg <= 1'b0;
         end
         if (wvalid && wready_reg) begin
            w_have_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end else if (do_write) begin
            w_have_reg <= 1'b0;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else begin
         arready_reg <= arvalid && !arready_reg && !rvalid_reg;
         if (arvalid && arready_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Operand selection and arithmetic
   wire [63:0] a = src_a_gpr_reg;
   wire [63:0] b = src_b_gpr_reg;
   wire [63:0] mul_hs = $signed(a[31:0]) * $signed(b[31:0]); // RULE_01 RULE_08
   wire [63:0] mul_hu = a[31:0] * b[31:0]; // RULE_02
   wire [15:0] imm16_val = imm_reg[IMM16_LSB +: 16];
   wire [15:0] split_imm = join_split(imm_reg); // RULE_07
   wire [63:0] sci_val = expand_byte_imm(ctrl_reg.sci_fill, ctrl_reg.sci_scale, ctrl_reg.sci_byte); // RULE_18
   // Low product bits do not depend on signedness, so one multiplier serves all low forms except the low-word multiply, which uses mul_hs
   wire [63:0] m_sel = ctrl_reg.op == OP_MULTIPLY_SIGNED_IMM16 ? {{48{imm16_val[15]}}, imm16_val} :
                       ctrl_reg.op == OP_MULTIPLY_SCALED_BYTE_IMM ? sci_val :
                       ctrl_reg.op == OP_MULTIPLY_IN_PLACE_IMM ? {{48{split_imm[15]}}, split_imm} : b;
   wire [63:0] mul_lo = a * m_sel; // RULE_05 RULE_06 RULE_07 RULE_11
   wire [63:0] or_sel = ctrl_reg.op == OP_OR_SCALED_BYTE_IMM ? sci_val :
                        ctrl_reg.op == OP_OR_LOW_HALF_IMM ? {48'h0, split_imm} :
                        ctrl_reg.op == OP_OR_HIGH_HALF_IMM ? {32'h0, split_imm, 16'h0000} : b;
   wire [63:0] neg_sum = ~a + 64'h1; // RULE_13 RULE_14
   wire [31:0] neg_low = {1'b0, ~a[30:0]} + 32'h0000_0001;
   wire neg_wide = neg_low[31] ^ (~a[31] & neg_low[31]); // RULE_15
   wire mul_wide = mul_hs[63:32] != 32'h0000_0000 && mul_hs[63:32] != 32'hFFFF_FFFF; // RULE_09

   logic [63:0] res_next;
   logic [31:0] cr_val;
   logic wb_en, cr_en, wide_en, wide_val;

   always_comb begin
      res_next = result_reg;
      cr_val = 32'h0000_0000;
      wb_en = 1'b0;
      cr_en = 1'b0;
      wide_en = 1'b0;
      wide_val = 1'b0;
      unique case (ctrl_reg.op)
         OP_MULTIPLY_HIGH_SIGNED: begin
            // Upper half is left as zero
            res_next = {32'h0000_0000, mul_hs[63:32]}; // RULE_01 RULE_03
            cr_val = mul_hs[63:32]; // RULE_04
            cr_en = ctrl_reg.cr_update_select;
         end
         OP_MULTIPLY_HIGH_UNSIGNED: begin
            res_next = {32'h0000_0000, mul_hu[63:32]}; // RULE_02 RULE_03
            cr_val = mul_hu[63:32]; // RULE_04
            cr_en = ctrl_reg.cr_update_select;
         end
         OP_MULTIPLY_SIGNED_IMM16: begin
            res_next = mul_lo; // RULE_05
         end
         OP_MULTIPLY_SCALED_BYTE_IMM: begin
            res_next = {32'h0000_0000, mul_lo[31:0]}; // RULE_06
         end
         OP_MULTIPLY_IN_PLACE_IMM: begin
            res_next = {a[63:32], mul_lo[31:0]}; // RULE_07
            wb_en = 1'b1;
         end
         OP_MULTIPLY_LOW_WORD: begin
            res_next = mul_hs; // RULE_08
            cr_val = mul_hs[31:0]; // RULE_10
            cr_en = ctrl_reg.cr_update_select;
            wide_en = ctrl_reg.overflow_check; // RULE_09
            wide_val = mul_wide;
         end
         OP_SHORT_MULTIPLY_LOW: begin
            res_next = {a[63:32], mul_lo[31:0]}; // RULE_11
            wb_en = 1'b1;
         end
         OP_NOT_AND: begin
            res_next = ~(a & b); // RULE_12
            cr_val = res_next[31:0];
            cr_en = ctrl_reg.cr_update_select;
         end
         OP_TWOS_COMPLEMENT: begin
            res_next = neg_sum; // RULE_13 RULE_14
            cr_val = neg_sum[31:0];
            cr_en = ctrl_reg.cr_update_select;
            wide_en = ctrl_reg.overflow_check; // RULE_15
            wide_val = neg_wide;
         end
         OP_SHORT_TWOS_COMPLEMENT: begin
            res_next = {a[63:32], neg_sum[31:0]}; // RULE_16
            wb_en = 1'b1;
         end
         OP_OR_SCALED_BYTE_IMM, OP_OR_LOW_HALF_IMM, OP_OR_HIGH_HALF_IMM: begin
            res_next = a | or_sel; // RULE_17
            cr_val = res_next[31:0];
            cr_en = ctrl_reg.cr_update_select;
         end
         OP_SHORT_OR_OP: begin
            res_next = a | or_sel; // RULE_17
         end
         default: begin
            res_next = result_reg;
         end
      endcase
   end

   // Flag update; a hardware set wins over a software clear in the same cycle
   wire wide_set = go_reg && wide_en && wide_val;
   wire so_next = (status_reg.sticky_error_flag && !(wr_status && w_data_reg[STATUS_SO_BIT])) || wide_set;
   always_comb begin
      status_next = status_reg;
      status_next.sticky_error_flag = so_next; // RULE_09 RULE_15
      if (go_reg && wide_en) begin
         status_next.result_too_wide_flag = wide_val;
      end else if (wr_status && w_data_reg[STATUS_WIDE_BIT]) begin
         status_next.result_too_wide_flag = 1'b0;
      end
      if (go_reg && cr_en) begin
         status_next.cond_field_zero = cr_of(cr_val, so_next); // RULE_04 RULE_10 RULE_12 RULE_13
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         src_a_gpr_reg <= 64'h0;
         src_b_gpr_reg <= 64'h0;
         imm_reg <= 32'h0000_0000;
         ctrl_reg <= CTRL_RESET;
         result_reg <= 64'h0;
         status_reg <= STATUS_RESET;
         go_reg <= 1'b0;
      end else begin
         go_reg <= wr_ctrl;
         status_reg <= status_next;
         if (go_reg) result_reg <= res_next;
         if (go_reg && wb_en) src_a_gpr_reg <= res_next; // RULE_07 RULE_11 RULE_16
         if (wr_a_lo) src_a_gpr_reg[31:0] <= merge(src_a_gpr_reg[31:0], w_data_reg, w_strb_reg);
         if (wr_a_hi) src_a_gpr_reg[63:32] <= merge(src_a_gpr_reg[63:32], w_data_reg, w_strb_reg);
         if (wr_b_lo) src_b_gpr_reg[31:0] <= merge(src_b_gpr_reg[31:0], w_data_reg, w_strb_reg);
         if (wr_b_hi) src_b_gpr_reg[63:32] <= merge(src_b_gpr_reg[63:32], w_data_reg, w_strb_reg);
         if (wr_imm) imm_reg <= merge(imm_reg, w_data_reg, w_strb_reg);
         if (wr_ctrl) ctrl_reg <= ctrl_t'(ctrl_merged[16:0]);
      end
   end

   property p_high_signed;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_HIGH_SIGNED |=> result_reg[31:0] == $past(mul_hs[63:32]);
   endproperty
   a_high_signed: assert property (p_high_signed) else $error("signed high word wrong"); // RULE_01

   property p_high_unsigned;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_HIGH_UNSIGNED |=> result_reg[31:0] == $past(mul_hu[63:32]);
   endproperty
   a_high_unsigned: assert property (p_high_unsigned) else $error("unsigned high word wrong"); // RULE_02

   property p_high_cr;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_HIGH_SIGNED && ctrl_reg.cr_update_select
      |=> status_reg.cond_field_zero[3] == $past(mul_hs[63]) && status_reg.cond_field_zero[1] == (result_reg[31:0] == 0);
   endproperty
   a_high_cr: assert property (p_high_cr) else $error("condition field after high multiply wrong"); // RULE_04

   property p_imm16;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_SIGNED_IMM16
      |=> result_reg == $past(a) * {{48{$past(imm16_val[15])}}, $past(imm16_val)};
   endproperty
   a_imm16: assert property (p_imm16) else $error("immediate product wrong"); // RULE_05

   property p_sci_noflags;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_SCALED_BYTE_IMM |=> $stable(status_reg);
   endproperty
   a_sci_noflags: assert property (p_sci_noflags) else $error("scaled multiply changed flags"); // RULE_06

   property p_low_word;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_LOW_WORD |=> result_reg == $past(mul_hs);
   endproperty
   a_low_word: assert property (p_low_word) else $error("low-word product wrong"); // RULE_08

   property p_low_wide;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_MULTIPLY_LOW_WORD && ctrl_reg.overflow_check && mul_wide
      |=> status_reg.result_too_wide_flag && status_reg.sticky_error_flag;
   endproperty
   a_low_wide: assert property (p_low_wide) else $error("overflow not flagged"); // RULE_09

   property p_nand;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_NOT_AND |=> result_reg == ~($past(a) & $past(b));
   endproperty
   a_nand: assert property (p_nand) else $error("not-and result wrong"); // RULE_12

   property p_neg_min;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_TWOS_COMPLEMENT && a == MOST_NEG64 |=> result_reg == MOST_NEG64;
   endproperty
   a_neg_min: assert property (p_neg_min) else $error("most negative value altered"); // RULE_14

   property p_neg_wide;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_TWOS_COMPLEMENT && ctrl_reg.overflow_check
      |=> status_reg.result_too_wide_flag == ($past(a[31:0]) == MOST_NEG32);
   endproperty
   a_neg_wide: assert property (p_neg_wide) else $error("negate overflow wrong"); // RULE_15

   property p_short_neg;
      @(posedge clock) disable iff (rst)
      go_reg && ctrl_reg.op == OP_SHORT_TWOS_COMPLEMENT
      |=> src_a_gpr_reg[31:0] == ~$past(a[31:0]) + 32'h0000_0001 && $stable(status_reg);
   endproperty
   a_short_neg: assert property (p_short_neg) else $error("short negate wrong"); // RULE_16
endmodule
